/* include/sp_pkg.sv */
// constants and types shared by the sync processing control block
package sp_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int SEP_TICK_NS = 200;
  localparam int SEP_TICK_CYC = (SEP_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int HS_LOSS_US = 100;
  localparam int HS_LOSS_CYC = HS_LOSS_US * 1000 / CLK_NS;
  localparam int VS_LOSS_MS = 100;
  localparam int VS_LOSS_CYC = VS_LOSS_MS * 1000000 / CLK_NS;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_DIV_UP = 8'h01;
  localparam logic [7:0] A_DIV_LO = 8'h02;
  localparam logic [7:0] A_SYNC_CTL = 8'h0E;
  localparam logic [7:0] A_CLAMP_CTL = 8'h10;
  localparam logic [7:0] A_SEP_THR = 8'h11;
  localparam logic [7:0] A_LEAD = 8'h12;
  localparam logic [7:0] A_TRAIL = 8'h13;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_TEST_A = 8'h15;
  localparam logic [7:0] A_TEST_B = 8'h16;
  localparam logic [7:0] A_TEST_C = 8'h17;
  localparam logic [7:0] A_TEST_D = 8'h18;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIV_UP = 8'h69;
  localparam logic [7:0] RST_DIV_LO = 8'hD0;
  localparam logic [11:0] RST_PLL_DIV = 12'h69D;
  localparam logic [7:0] RST_SYNC_CTL = 8'h40;
  localparam logic [7:0] RST_CLAMP_CTL = 8'hB8;
  localparam logic [7:0] RST_SEP_THR = 8'h20;
  localparam logic [7:0] RST_LEAD = 8'h00;
  localparam logic [7:0] RST_TRAIL = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SC_AHS_OVR = 4;
  localparam int SC_AHS_SEL = 3;
  localparam int SC_VS_INV = 2;
  localparam int SC_AVS_OVR = 1;
  localparam int SC_AVS_SEL = 0;
  localparam int CC_BLUE_MID = 0;
  // sync input channels
  localparam int CH_HS = 0;
  localparam int CH_SOG = 1;
  localparam int CH_VS = 2;
  localparam int CH_COAST = 3;
  localparam int NCH = 4;
  localparam int RUN_W = 16;
  localparam int ACT_W = 20;
  localparam int LINE_W = 11;
  // serial slave address, value arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h4C;
  // two-wire slave states
  typedef enum logic [3:0] {S_IDLE, S_ADDR, S_ACK_A, S_SUB, S_ACK_S, S_WDATA, S_ACK_W, S_RDATA, S_ACK_R} sp_bus_e;
endpackage

/* hw/sp_ctrl.sv */
// sync processing control and status registers behind a two-wire serial slave
module sp_ctrl
  import sp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
  parameter int HS_LOSS = HS_LOSS_CYC,
  parameter int VS_LOSS = VS_LOSS_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic hsync_pin,
  input wire logic sog_pin,
  input wire logic vsync_pin,
  input wire logic coast_pin,
  output logic blue_clamp_mid,
  output logic [11:0] pll_divide_ratio,
  output logic sep_vsync,
  output logic vsync_out,
  output logic coast_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    sp_bus_e st;
    logic [3:0] bitn;
    logic [7:0] sh, ptr;
    logic rw, oe;
    logic [7:0] div_up, div_lo, sync_ctl, clamp_ctl, sep_thr, lead, trail, test_a, test_b;
    logic [11:0] pll_div;
    logic [NCH-1:0] pin_s1, pin_s2, pin_d, pres, pol;
    logic [NCH-1:0][RUN_W-1:0] run, hi_len, lo_len;
    logic [NCH-1:0][ACT_W-1:0] act;
    logic [1:0] tick_cnt;
    logic [7:0] sep_cnt;
    logic sep_vs, hs_d, vs_d, coast, vs_out;
    logic [LINE_W-1:0] line_cnt, frame_lines;
  } sp_state_s;
  sp_state_s r_ff, nxt_r;
  logic active_horizontal_source, active_vertical_source, hs_act, vs_act, raw_vs;
  logic scl_rise, scl_fall, bus_start, bus_stop, wr_ev;
  logic [7:0] status;
  // register read mux
  function automatic logic [7:0] reg_read(input sp_state_s s, input logic [7:0] a, input logic [7:0] stat);
    logic [7:0] d;
    case (a)
      A_DIV_UP: d = s.div_up;
      A_DIV_LO: d = s.div_lo;
      A_SYNC_CTL: d = s.sync_ctl;
      A_CLAMP_CTL: d = s.clamp_ctl;
      A_SEP_THR: d = s.sep_thr;
      A_LEAD: d = s.lead;
      A_TRAIL: d = s.trail;
      A_STATUS: d = stat;
      A_TEST_A: d = s.test_a;
      A_TEST_B: d = s.test_b;
      default: d = 8'h00;
    endcase
    return d;
  endfunction
  // ----------------------------------------------------------------
  // source selection and status
  // ----------------------------------------------------------------
  // hsync source: override, else pick whichever is present
  assign active_horizontal_source = r_ff.sync_ctl[SC_AHS_OVR] ? r_ff.sync_ctl[SC_AHS_SEL] :
               (r_ff.pres[CH_HS] && r_ff.pres[CH_SOG]) ? r_ff.sync_ctl[SC_AHS_SEL] :
               (!r_ff.pres[CH_HS] && r_ff.pres[CH_SOG]);
  assign active_vertical_source = r_ff.sync_ctl[SC_AVS_OVR] ? r_ff.sync_ctl[SC_AVS_SEL] : !r_ff.pres[CH_VS];
  // normalise selected syncs to active high
  assign hs_act = active_horizontal_source ? (r_ff.pin_s2[CH_SOG] ~^ r_ff.pol[CH_SOG]) : (r_ff.pin_s2[CH_HS] ~^ r_ff.pol[CH_HS]);
  assign raw_vs = r_ff.pin_s2[CH_VS] ~^ r_ff.pol[CH_VS];
  assign vs_act = active_vertical_source ? r_ff.sep_vs : raw_vs;
  assign status = {r_ff.pres[CH_HS], active_horizontal_source, r_ff.pol[CH_HS], r_ff.pres[CH_VS], active_vertical_source,
                   ~r_ff.sync_ctl[SC_VS_INV], r_ff.pres[CH_SOG], r_ff.pol[CH_COAST]};

  // serial bus conditions
  assign scl_rise = r_ff.scl_s2 && !r_ff.scl_d;
  assign scl_fall = !r_ff.scl_s2 && r_ff.scl_d;
  assign bus_start = r_ff.scl_s2 && r_ff.scl_d && r_ff.sda_d && !r_ff.sda_s2;
  assign bus_stop = r_ff.scl_s2 && r_ff.scl_d && !r_ff.sda_d && r_ff.sda_s2;
  assign wr_ev = scl_fall && !bus_start && !bus_stop && r_ff.st == S_WDATA && r_ff.bitn == 4'h8;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] rd;
    rd = reg_read(r_ff, r_ff.ptr, status);
    nxt_r = r_ff;
    // synchronisers, then one more stage for edge detection
    {nxt_r.scl_s1, nxt_r.scl_s2, nxt_r.scl_d} = {scl_in, r_ff.scl_s1, r_ff.scl_s2};
    {nxt_r.sda_s1, nxt_r.sda_s2, nxt_r.sda_d} = {sda_in, r_ff.sda_s1, r_ff.sda_s2};
    {nxt_r.pin_s1, nxt_r.pin_s2, nxt_r.pin_d} = {coast_pin, vsync_pin, sog_pin, hsync_pin, r_ff.pin_s1, r_ff.pin_s2};
    // two-wire slave
    if (bus_start)
    begin
      nxt_r.st = S_ADDR;
      nxt_r.bitn = 4'h0;
      nxt_r.oe = 1'h0;
    end
    else if (bus_stop)
    begin
      nxt_r.st = S_IDLE;
      nxt_r.oe = 1'h0;
    end
    else if (scl_rise)
    begin
      unique case (r_ff.st)
        S_ADDR, S_SUB, S_WDATA:
        begin
          nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s2};
          nxt_r.bitn = r_ff.bitn + 4'h1;
        end
        S_RDATA: nxt_r.bitn = r_ff.bitn + 4'h1;
        S_ACK_R: if (r_ff.sda_s2) nxt_r.st = S_IDLE;
        S_IDLE, S_ACK_A, S_ACK_S, S_ACK_W: ;
        default: nxt_r.st = S_IDLE;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (r_ff.st)
        S_ADDR:
          if (r_ff.bitn == 4'h8)
          begin
            if (r_ff.sh[7:1] == DEV_ADDR)
            begin
              nxt_r.st = S_ACK_A;
              nxt_r.rw = r_ff.sh[0];
              nxt_r.oe = 1'h1;
            end
            else
              nxt_r.st = S_IDLE;
          end
        S_ACK_A:
          if (r_ff.rw)
          begin
            nxt_r.sh = rd;
            nxt_r.oe = ~rd[7];
            nxt_r.bitn = 4'h0;
            nxt_r.st = S_RDATA;
          end
          else
          begin
            nxt_r.oe = 1'h0;
            nxt_r.bitn = 4'h0;
            nxt_r.st = S_SUB;
          end
        S_SUB:
          if (r_ff.bitn == 4'h8)
          begin
            nxt_r.ptr = r_ff.sh;
            nxt_r.oe = 1'h1;
            nxt_r.st = S_ACK_S;
          end
        S_ACK_S, S_ACK_W:
        begin
          nxt_r.oe = 1'h0;
          nxt_r.bitn = 4'h0;
          nxt_r.st = S_WDATA;
        end
        S_WDATA:
          if (r_ff.bitn == 4'h8)
          begin
            nxt_r.ptr = r_ff.ptr + 8'h01;
            nxt_r.oe = 1'h1;
            nxt_r.st = S_ACK_W;
          end
        S_RDATA:
          if (r_ff.bitn == 4'h8)
          begin
            nxt_r.oe = 1'h0;
            nxt_r.ptr = r_ff.ptr + 8'h01;
            nxt_r.st = S_ACK_R;
          end
          else
            nxt_r.oe = ~r_ff.sh[3'(7 - int'(r_ff.bitn))];
        S_ACK_R:
        begin
          nxt_r.sh = rd;
          nxt_r.oe = ~rd[7];
          nxt_r.bitn = 4'h0;
          nxt_r.st = S_RDATA;
        end
        S_IDLE: ;
        default: nxt_r.st = S_IDLE;
      endcase
    end
    // register writes
    if (wr_ev)
    begin
      case (r_ff.ptr)
        A_DIV_UP: nxt_r.div_up = r_ff.sh;
        A_DIV_LO:
        begin
          nxt_r.div_lo = r_ff.sh;
          nxt_r.pll_div = {r_ff.div_up, r_ff.sh[7:4]};
        end
        A_SYNC_CTL: nxt_r.sync_ctl = r_ff.sh;
        A_CLAMP_CTL: nxt_r.clamp_ctl = r_ff.sh;
        A_SEP_THR: nxt_r.sep_thr = r_ff.sh;
        A_LEAD: nxt_r.lead = r_ff.sh;
        A_TRAIL: nxt_r.trail = r_ff.sh;
        A_TEST_A: nxt_r.test_a = r_ff.sh;
        A_TEST_B: nxt_r.test_b = r_ff.sh;
        default: ;
      endcase
    end
    // activity and polarity per sync input
    for (int i = 0; i < NCH; i++)
    begin
      if (r_ff.pin_s2[i] != r_ff.pin_d[i])
      begin
        if (r_ff.pin_s2[i])
          nxt_r.lo_len[i] = r_ff.run[i];
        else
          nxt_r.hi_len[i] = r_ff.run[i];
        nxt_r.run[i] = '0;
        nxt_r.act[i] = '0;
        nxt_r.pres[i] = 1'h1;
        nxt_r.pol[i] = nxt_r.hi_len[i] < nxt_r.lo_len[i];
      end
      else
      begin
        if (r_ff.run[i] != '1)
          nxt_r.run[i] = r_ff.run[i] + 16'h0001;
        if (r_ff.act[i] >= ACT_W'((i >= CH_VS) ? VS_LOSS : HS_LOSS))
          nxt_r.pres[i] = 1'h0;
        else
          nxt_r.act[i] = r_ff.act[i] + 20'h00001;
      end
    end
    // sync separator on 5 MHz ticks
    nxt_r.tick_cnt = (r_ff.tick_cnt == 2'(SEP_TICK_CYC - 1)) ? 2'h0 : r_ff.tick_cnt + 2'h1;
    if (hs_act == r_ff.sep_vs)
      nxt_r.sep_cnt = 8'h00;
    else if (r_ff.sep_cnt >= r_ff.sep_thr)
    begin
      nxt_r.sep_vs = hs_act;
      nxt_r.sep_cnt = 8'h00;
    end
    else if (r_ff.tick_cnt == 2'(SEP_TICK_CYC - 1))
      nxt_r.sep_cnt = r_ff.sep_cnt + 8'h01;
    // line count between vsyncs, coast window
    {nxt_r.hs_d, nxt_r.vs_d} = {hs_act, vs_act};
    if (vs_act && !r_ff.vs_d)
    begin
      nxt_r.frame_lines = r_ff.line_cnt;
      nxt_r.line_cnt = '0;
    end
    else if (hs_act && !r_ff.hs_d && r_ff.line_cnt != '1)
      nxt_r.line_cnt = r_ff.line_cnt + 11'h001;
    nxt_r.coast = vs_act
                  || (r_ff.lead != 8'h00 && 12'(r_ff.line_cnt) + 12'(r_ff.lead) >= 12'(r_ff.frame_lines))
                  || (12'(r_ff.line_cnt) < 12'(r_ff.trail));
    nxt_r.vs_out = vs_act ^ r_ff.sync_ctl[SC_VS_INV];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      r_ff <= '{scl_s1: 1'h1, scl_s2: 1'h1, scl_d: 1'h1, sda_s1: 1'h1, sda_s2: 1'h1, sda_d: 1'h1, st: S_IDLE,
                div_up: RST_DIV_UP, div_lo: RST_DIV_LO, pll_div: RST_PLL_DIV, sync_ctl: RST_SYNC_CTL,
                clamp_ctl: RST_CLAMP_CTL, sep_thr: RST_SEP_THR, lead: RST_LEAD, trail: RST_TRAIL,
                test_a: RST_TEST, test_b: RST_TEST, default: '0}; // bus lines rest high
    else
      r_ff <= nxt_r;
  end
  // outputs, open-drain data pulls low only
  assign sda_out = 1'h0;
  assign sda_oe = r_ff.oe;
  assign blue_clamp_mid = r_ff.clamp_ctl[CC_BLUE_MID];
  assign pll_divide_ratio = r_ff.pll_div;
  assign sep_vsync = r_ff.sep_vs;
  assign vsync_out = r_ff.vs_out;
  assign coast_out = r_ff.coast;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PLL_COMMIT: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(pll_divide_ratio) |-> $past(wr_ev) && $past(r_ff.ptr) == A_DIV_LO)
    else $error("divide ratio changed without low-bits write");
  AST_UPPER_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    wr_ev && r_ff.ptr == A_DIV_UP |=> $stable(pll_divide_ratio) ##1 $stable(pll_divide_ratio))
    else $error("upper-bits write moved divide ratio");
  AST_BLUE_CLAMP: assert property (@(posedge sys_clk) disable iff (reset)
    wr_ev && r_ff.ptr == A_CLAMP_CTL |=> blue_clamp_mid == $past(r_ff.sh[0]))
    else $error("blue clamp select not taken from write");
  AST_SEP_THR: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(sep_vsync) |-> $past(r_ff.sep_cnt >= r_ff.sep_thr))
    else $error("separator toggled before threshold");
  AST_STATUS_RO: assert property (@(posedge sys_clk) disable iff (reset)
    wr_ev && r_ff.ptr == A_STATUS |=> $stable(r_ff.sync_ctl) && $stable(r_ff.test_a) && $stable(r_ff.sep_thr))
    else $error("write to status disturbed a register");
  AST_TRAIL: assert property (@(posedge sys_clk) disable iff (reset)
    12'(r_ff.line_cnt) < 12'(r_ff.trail) |=> coast_out)
    else $error("coast dropped inside trailing window");
  AST_LEAD: assert property (@(posedge sys_clk) disable iff (reset)
    r_ff.lead != 8'h00 && 12'(r_ff.line_cnt) + 12'(r_ff.lead) >= 12'(r_ff.frame_lines) |=> coast_out)
    else $error("coast missing inside leading window");
  AST_HS_PRESENT: assert property (@(posedge sys_clk) disable iff (reset)
    r_ff.pin_s2[CH_HS] != r_ff.pin_d[CH_HS] |=> status[7])
    else $error("hsync edge did not mark hsync present");
  AST_AUTO_SRC: assert property (@(posedge sys_clk) disable iff (reset)
    !r_ff.sync_ctl[SC_AHS_OVR] && !r_ff.pres[CH_HS] && r_ff.pres[CH_SOG] |-> status[6])
    else $error("automatic hsync source not green sync");
endmodule

/* bench/sp_src.sv */
// analog video source model: hsync, sync on green, vsync and coast
module sp_src
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic h_en,
  input wire logic g_en,
  input wire logic v_en,
  input wire logic act_hi,
  input wire logic comp,
  output logic hsync_pin,
  output logic sog_pin,
  output logic vsync_pin,
  output logic coast_pin,
  output logic [3:0] line_no,
  output logic [5:0] cyc_no
);
  timeunit 1ns;
  timeprecision 1ns;
  logic h_act;
  logic v_act;
  logic c_act;
  // line of 40 cycles, frame of 10 lines
  always @(posedge sys_clk)
  begin
    if (reset || cyc_no == 6'h27)
    begin
      cyc_no <= 6'h00;
      line_no <= (reset || line_no == 4'h9) ? 4'h0 : line_no + 4'h1;
    end
    else
      cyc_no <= cyc_no + 6'h01;
  end
  // 4 cycle hsync, broad pulse in line 0 when comp, vsync from mid line 0 to mid line 1
  assign h_act = cyc_no < 6'h04 || (comp && line_no == 4'h0 && cyc_no < 6'h10);
  assign v_act = (line_no == 4'h0 && cyc_no >= 6'h14) || (line_no == 4'h1 && cyc_no < 6'h14);
  assign c_act = line_no == 4'h0 && cyc_no < 6'h08;
  // a disabled source rests at its inactive level
  assign hsync_pin = h_en ? h_act == act_hi : !act_hi;
  assign sog_pin = g_en ? h_act == act_hi : !act_hi;
  assign vsync_pin = v_en ? v_act == act_hi : !act_hi;
  assign coast_pin = v_en ? c_act == act_hi : !act_hi;
endmodule

/* bench/testbench.sv */
// self-checking bench for the sync processing control block
module testbench
  import sp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic h_en = 1'b0, g_en = 1'b0, v_en = 1'b0, act_hi = 1'b1, comp = 1'b0;
  logic sda_out, sda_oe, hs, sg, vs, cp, blue, sepv, vso, coast, rd_flag;
  logic [11:0] pll;
  logic [3:0] line_no;
  logic [5:0] cyc_no;
  logic [7:0] rd_byte, v;
  logic [7:0] exp_q[$];
  logic [7:0] rq[$];
  logic [3:0] fl[5] = '{4'h0, 4'h2, 4'h3, 4'h7, 4'h8};
  logic fc[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int mismatches = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  // open drain wire with pull-up
  wire logic sda_w = sda_oe ? sda_out : sda_m;

  sp_ctrl #(.HS_LOSS(50), .VS_LOSS(2000)) sp_ctrl_inst (.sys_clk(sys_clk), .reset(reset), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .hsync_pin(hs), .sog_pin(sg), .vsync_pin(vs),
    .coast_pin(cp), .blue_clamp_mid(blue), .pll_divide_ratio(pll), .sep_vsync(sepv), .vsync_out(vso),
    .coast_out(coast));
  sp_src sp_src_inst (.sys_clk(sys_clk), .reset(reset), .h_en(h_en), .g_en(g_en), .v_en(v_en),
    .act_hi(act_hi), .comp(comp), .hsync_pin(hs), .sog_pin(sg), .vsync_pin(vs), .coast_pin(cp),
    .line_no(line_no), .cyc_no(cyc_no));

  // 10 MHz clock
  initial
    forever #50 sys_clk = ~sys_clk;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_val(input logic [11:0] got, input logic [11:0] e);
    checks_done++;
    if (got !== e)
    begin
      mismatches++;
      $display("ERROR %0t port %h expected %h", $time, got, e);
    end
  endtask
  task automatic chk_rd();
    logic [7:0] e;
    if (exp_q.size() > 0)
      e = exp_q.pop_front();
    checks_done++;
    if (rd_byte !== e)
    begin
      mismatches++;
      $display("ERROR %0t read %h expected %h", $time, rd_byte, e);
    end
  endtask
  // each byte read back is matched with the oldest note
  always @(posedge sys_clk)
    if (rd_flag === 1'b1)
      chk_rd();
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 40000)
    begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------
  // two-wire master
  // ----------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic xbit(input logic b, output logic r);
    w(2);
    sda_m <= b;
    w(3);
    scl <= 1'b1;
    w(5);
    r = sda_w;
    scl <= 1'b0;
  endtask
  task automatic start();
    w(2);
    sda_m <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(5);
    sda_m <= 1'b0;
    w(5);
    scl <= 1'b0;
  endtask
  task automatic stop();
    w(2);
    sda_m <= 1'b0;
    w(3);
    scl <= 1'b1;
    w(5);
    sda_m <= 1'b1;
    w(5);
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    start();
    tx({DEV_ADDR_DEF, 1'b0});
    tx(a);
    foreach (d[i])
      tx(d[i]);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic r;
    logic [7:0] b;
    start();
    tx({DEV_ADDR_DEF, 1'b0});
    tx(a);
    start();
    tx({DEV_ADDR_DEF, 1'b1});
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
        xbit(1'b1, b[i]);
      xbit(k == n - 1, r);
      rd_byte <= b;
      rd_flag <= 1'b1;
      w(1);
      rd_flag <= 1'b0;
    end
    stop();
  endtask
  // wait for a frame position, then check coast, vsync and separator
  task automatic fchk(input logic [3:0] l, input logic [5:0] c, input logic ec, input logic ev, input logic es);
    int t;
    t = 0;
    while ((line_no !== l || cyc_no !== c) && t < 1000)
    begin
      w(1);
      t++;
    end
    if (t >= 1000)
    begin
      mismatches++;
      $display("ERROR %0t frame position not reached", $time);
    end
    chk_val({11'h000, coast}, {11'h000, ec});
    chk_val({11'h000, vso}, {11'h000, ev});
    chk_val({11'h000, sepv}, {11'h000, es});
  endtask

  // main sequence
  initial
  begin
    void'($urandom(53));
    w(16);
    reset <= 1'b0;
    w(3);
    exp_q = '{8'h20, 8'h00, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00};
    rd(A_SEP_THR, 8);
    chk_val(pll, RST_PLL_DIV);
    // random burst over the upper map, status and read-only test places ignore it
    for (int i = 0; i < 8; i++)
      rq.push_back(8'($urandom()));
    wr(A_SEP_THR, rq);
    wr(8'h30, '{8'hA5});
    exp_q = '{rq[0], rq[1], rq[2], 8'h0C, rq[4], rq[5], 8'h00, 8'h00, 8'h00};
    rd(A_SEP_THR, 8);
    rd(8'h30, 1);
    // midscale first, so both checks see a change
    for (int i = 0; i < 2; i++)
    begin
      wr(A_CLAMP_CTL, '{RST_CLAMP_CTL | 8'(1 - i)});
      chk_val({11'h000, blue}, 12'(1 - i));
    end
    v = 8'($urandom());
    wr(A_DIV_UP, '{v});
    chk_val(pll, RST_PLL_DIV);
    wr(A_DIV_LO, '{8'h5F});
    chk_val(pll, {v, 4'h5});
    // active-high syncs, threshold of 16 cycles: above the 4 cycle pulse, below the 36 cycle gap
    wr(A_SEP_THR, '{8'h08, 8'h00, 8'h00});
    h_en <= 1'b1;
    v_en <= 1'b1;
    w(800);
    fchk(4'h2, 6'h1E, 1'b0, 1'b0, 1'b0);
    fchk(4'h8, 6'h1E, 1'b0, 1'b0, 1'b0);
    wr(A_LEAD, '{8'h02, 8'h03});
    w(800);
    foreach (fl[i])
      fchk(fl[i], 6'h1E, fc[i], i == 0, 1'b0);
    exp_q = '{8'hB5, 8'hB1};
    rd(A_STATUS, 1);
    wr(A_SYNC_CTL, '{8'h44});
    rd(A_STATUS, 1);
    fchk(4'h5, 6'h1E, 1'b0, 1'b1, 1'b0);
    wr(A_SYNC_CTL, '{RST_SYNC_CTL});
    // broad pulse of 16 cycles against thresholds of 8 and 24 cycles
    comp <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(A_SEP_THR, '{8'(4 + 8 * i)});
      w(800);
      fchk(4'h0, 6'h0F, 1'b1, 1'b0, i == 0);
    end
    comp <= 1'b0;
    // active-low syncs, green sync added, then green alone
    act_hi <= 1'b0;
    g_en <= 1'b1;
    w(1200);
    exp_q = '{8'h96, 8'hD6};
    rd(A_STATUS, 1);
    wr(A_SYNC_CTL, '{8'h58});
    rd(A_STATUS, 1);
    wr(A_SYNC_CTL, '{RST_SYNC_CTL, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF});
    h_en <= 1'b0;
    v_en <= 1'b0;
    w(2500);
    exp_q = '{8'h4E};
    rd(A_STATUS, 1);
    test_done();
  end
endmodule
